/* File: byte_parity_check.sv */
// odd parity check of both bytes of a storage word
`timescale 1ns/1ps
`default_nettype none
module byte_parity_check (
    input  wire logic [15:0] data,
    input  wire logic [1:0]  parity,
    output logic [1:0]       byte_err
);
    // ********************************************************************
    // checker
    // ********************************************************************
    // a good byte plus its parity bit holds an odd count of ones
    always_comb begin
        byte_err[0] = ~(^{data[15:8], parity[0]});
        byte_err[1] = ~(^{data[7:0], parity[1]});
    end
endmodule
`default_nettype wire

/* File: main_store_model.sv */
// behavioural main storage answering reads after its access time
`timescale 1ns/1ps
`default_nettype none
module main_store_model #(
    parameter int ACC_NS = 385,
    parameter int CYC_NS = 900
) (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic        corrupt,
    output logic [15:0]      read_data,
    output logic [1:0]       read_parity
);
    int          n = 999;
    logic [15:0] w = 16'hC35A;
    logic [15:0] junk = 16'h0000;
    // one storage cycle at a time, a start inside a busy cycle is lost
    always @(posedge clk) begin
        junk <= ~junk + 16'h1357;  // undriven bus never holds old data
        if (start && n >= CYC_NS / 10) begin
            n <= 0;
            w <= {w[14:0], w[15]};
        end else if (n < 999) begin
            n <= n + 1;
        end
    end
    // word only between access time and cycle end, odd parity per byte
    always_comb begin
        if (n >= (ACC_NS + 9) / 10 && n < CYC_NS / 10) begin
            read_data = w;
            read_parity = {~^w[7:0], ~^w[15:8] ^ corrupt};
        end else begin
            read_data = junk;
            read_parity = junk[1:0];
        end
    end
endmodule
`default_nettype wire

/* File: slice_counter.sv */
// time slice position counter: minor cycles and ticks
`timescale 1ns/1ps
`default_nettype none
module slice_counter (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    output logic [stc_pkg::POS_W-1:0]       pos,
    output logic [stc_pkg::TICK_W-1:0]      tick,
    output logic [stc_pkg::MINOR_W-1:0]     minor
);
    // ********************************************************************
    // counters
    // ********************************************************************
    // the three counts move together so decode can use any of them
    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_LAST) begin
            pos   <= '0;
            tick  <= '0;
            minor <= '0;
        end else begin
            pos <= pos + 1'b1;
            if (tick == stc_pkg::T_LAST) begin
                tick  <= '0;
                minor <= minor + 1'b1;
            end else begin
                tick <= tick + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: stc_pkg.sv */
// constants and helpers for the storage interface timing control block
package stc_pkg;

    // ********************************************************************
    // clock and time slice
    // ********************************************************************
    localparam int CLK_NS           = 10;
    localparam int MINOR_NS         = 100;
    localparam int TICKS_PER_MINOR  = MINOR_NS / CLK_NS;
    localparam int MINORS_PER_SLICE = 8;
    localparam int SLICE_TICKS      = TICKS_PER_MINOR * MINORS_PER_SLICE;
    localparam int POS_W            = 7;
    localparam int TICK_W           = 4;
    localparam int MINOR_W          = 3;

    // storage figures kept by main storage itself
    localparam int ACCESS_NS        = 385;
    localparam int CYCLE_NS         = 900;
    localparam int CYCLE_ECC_NS     = 1000;

    // slice points in ns from the slice start (E000)
    localparam int E040_NS = 40;
    localparam int E100_NS = 100;
    localparam int E150_NS = 150;
    localparam int E160_NS = 160;
    localparam int E400_NS = 400;
    localparam int E480_NS = 480;
    localparam int E500_NS = 500;
    localparam int E510_NS = 510;
    localparam int E600_NS = 600;
    // points inside a minor cycle
    localparam int T20_NS  = 20;
    localparam int T40_NS  = 40;

    // ns to slice position in clock ticks
    function automatic logic [POS_W-1:0] pos_of(input int ns);
        pos_of = POS_W'(ns / CLK_NS);
    endfunction

    localparam logic [POS_W-1:0]  P_E040 = pos_of(E040_NS);
    localparam logic [POS_W-1:0]  P_E100 = pos_of(E100_NS);
    localparam logic [POS_W-1:0]  P_E150 = pos_of(E150_NS);
    localparam logic [POS_W-1:0]  P_E160 = pos_of(E160_NS);
    localparam logic [POS_W-1:0]  P_E400 = pos_of(E400_NS);
    localparam logic [POS_W-1:0]  P_E480 = pos_of(E480_NS);
    localparam logic [POS_W-1:0]  P_E500 = pos_of(E500_NS);
    localparam logic [POS_W-1:0]  P_E510 = pos_of(E510_NS);
    localparam logic [POS_W-1:0]  P_E600 = pos_of(E600_NS);
    localparam logic [POS_W-1:0]  P_LAST = POS_W'(SLICE_TICKS - 1);
    localparam logic [TICK_W-1:0] T_T20  = TICK_W'(T20_NS / CLK_NS);
    localparam logic [TICK_W-1:0] T_T40  = TICK_W'(T40_NS / CLK_NS);
    localparam logic [TICK_W-1:0] T_LAST = TICK_W'(TICKS_PER_MINOR - 1);

    // transient registers that name a protection unit reference
    localparam logic [4:0] SRC_PROT_A = 5'h1E;
    localparam logic [4:0] SRC_PROT_B = 5'h1F;

    // ********************************************************************
    // register map
    // ********************************************************************
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_POS    = 12'h008;
    localparam int CTRL_ECC_BIT   = 0;
    localparam int CTRL_PCHK_BIT  = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam int ST_PERR_BIT    = 0;
    localparam int ST_RESYNC_BIT  = 1;
    localparam int ST_SHOLD_BIT   = 2;
    localparam int ST_AHOLD_BIT   = 3;
    localparam int ST_WFLAG_BIT   = 4;
    localparam int ST_PROT_BIT    = 5;

endpackage

/* File: storage_interface_timing_control.sv */
// storage and protection unit interface timing control
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module storage_interface_timing_control (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        load_addr_dec,
    input  wire logic        load_wdata_dec,
    input  wire logic        store_rdata_dec,
    input  wire logic        rdata_alu_dec,
    input  wire logic [4:0]  addr_src_reg,
    input  wire logic        maint_block_access,
    input  wire logic        register_address_bit4,
    input  wire logic        word_access,
    input  wire logic        byte_addr_bit15,
    input  wire logic [15:0] read_data,
    input  wire logic [1:0]  read_parity,
    input  wire logic        ecc_uncorrectable,
    output logic             main_store_write_flag,
    output logic             upper_byte_store_strobe,
    output logic             lower_byte_store_strobe,
    output logic             store_side_read_hold_n,
    output logic             alu_side_read_hold_n,
    output logic             storage_read_data_gate,
    output logic             protect_unit_register_select_n,
    output logic             ecc_register_select_n,
    output logic             protect_unit_read_gate,
    output logic             storage_access_initiate,
    output logic             resync_hold,
    output logic             block_next_load,
    output logic             file_load_strobe,
    output logic             alu_load_strobe,
    output logic             parity_error
);
    // ********************************************************************
    // slice position
    // ********************************************************************
    logic [stc_pkg::POS_W-1:0]   pos;
    logic [stc_pkg::TICK_W-1:0]  tick;
    logic [stc_pkg::MINOR_W-1:0] minor;
    logic [1:0]                  byte_err;

    slice_counter u_slice (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pos     (pos),
        .tick    (tick),
        .minor   (minor)
    );

    byte_parity_check u_par (
        .data     (read_data),
        .parity   (read_parity),
        .byte_err (byte_err)
    );

    // ********************************************************************
    // reference state
    // ********************************************************************
    logic ref_q;
    logic prot_q;
    logic bit4_q;
    logic write_q;
    logic prot_src;
    logic store_hold_q;
    logic alu_hold_q;
    logic rdata_avail_q;
    logic alu_pend_q;
    logic [1:0] ctrl_q;
    logic perr_q;

    assign prot_src = (addr_src_reg == stc_pkg::SRC_PROT_A)
                   || (addr_src_reg == stc_pkg::SRC_PROT_B)
                   || maint_block_access;

    // a reference only starts at E000; it lives for one slice
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_q  <= 1'b0;
            prot_q <= 1'b0;
            bit4_q <= 1'b0;
        end else if (pos == '0) begin
            ref_q  <= load_addr_dec;
            prot_q <= load_addr_dec && prot_src;
            bit4_q <= register_address_bit4;
        end
    end

    // write reference is named by load write data in minor cycle 1
    always_ff @(posedge clk) begin
        if (sys_rst || pos == '0) begin
            write_q <= 1'b0;
        end else if (pos == stc_pkg::P_E100) begin
            write_q <= ref_q && load_wdata_dec;
        end
    end

    // load address outside E0 idles the sequencer till next slice
    always_ff @(posedge clk) begin
        if (sys_rst || pos == '0) begin
            resync_hold <= 1'b0;
        end else if (tick == '0 && minor != '0 && load_addr_dec) begin
            resync_hold <= 1'b1;
        end
    end

    // initiate stands through minor cycle 0; protect refs never start
    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_E100) begin
            storage_access_initiate <= 1'b0;
        end else if (pos == '0) begin
            storage_access_initiate <= load_addr_dec && !prot_src;
        end
    end

    // ********************************************************************
    // write flag and strobes
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst || pos == '0) begin
            main_store_write_flag <= 1'b0;
        end else if (pos == stc_pkg::P_E160 && write_q) begin
            main_store_write_flag <= 1'b1;
        end
    end

    // bit15 low picks the upper byte; word access takes both
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upper_byte_store_strobe <= 1'b0;
            lower_byte_store_strobe <= 1'b0;
        end else begin
            upper_byte_store_strobe <= main_store_write_flag
                && (word_access || !byte_addr_bit15);
            lower_byte_store_strobe <= main_store_write_flag
                && (word_access || byte_addr_bit15);
        end
    end

    // ********************************************************************
    // read holds
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            store_hold_q <= 1'b0;
        end else if (pos == stc_pkg::P_E040 && ref_q) begin
            store_hold_q <= 1'b1;
        end else if (pos == stc_pkg::P_E160 && write_q) begin
            store_hold_q <= 1'b0;
        end else if (pos == stc_pkg::P_E510) begin
            store_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alu_hold_q <= 1'b0;
        end else if (pos == stc_pkg::P_E040 && ref_q) begin
            alu_hold_q <= 1'b1;
        end else if (pos == stc_pkg::P_E160 && write_q) begin
            alu_hold_q <= 1'b0;
        end else if (pos == stc_pkg::P_E400) begin
            alu_hold_q <= 1'b0;
        end
    end

    // hold outputs are active low copies, one edge behind the internal state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            store_side_read_hold_n <= 1'b1;
            alu_side_read_hold_n   <= 1'b1;
            block_next_load        <= 1'b0;
        end else begin
            store_side_read_hold_n <= !store_hold_q;
            alu_side_read_hold_n   <= !alu_hold_q;
            // the sequencer samples this at the end of the minor cycle
            block_next_load <= (store_hold_q && store_rdata_dec)
                            || (alu_hold_q && rdata_alu_dec)
                            || resync_hold;
        end
    end

    // ********************************************************************
    // fan-in gates and selects
    // ********************************************************************
    // ecc register data rides the storage gate, not the protect gate
    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_E600) begin
            storage_read_data_gate <= 1'b0;
        end else if (pos == stc_pkg::P_E400 && ref_q && !write_q
                     && !(prot_q && !bit4_q)) begin
            storage_read_data_gate <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_E600) begin
            protect_unit_read_gate <= 1'b0;
        end else if (pos == stc_pkg::P_E040 && prot_q && !bit4_q) begin
            protect_unit_read_gate <= 1'b1;
        end
    end

    // select window lets the load address steer the register address
    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_E150) begin
            protect_unit_register_select_n <= 1'b1;
            ecc_register_select_n          <= 1'b1;
        end else if (pos == stc_pkg::P_E040 && prot_q) begin
            protect_unit_register_select_n <= bit4_q;
            ecc_register_select_n          <= !bit4_q;
        end
    end

    // ********************************************************************
    // read data transfers
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst || pos == stc_pkg::P_E600) begin
            rdata_avail_q <= 1'b0;
        end else if (pos == stc_pkg::P_E480 && storage_read_data_gate) begin
            rdata_avail_q <= 1'b1;
        end
    end

    // file load at t40 of the starting cycle; earliest is E540
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_load_strobe <= 1'b0;
        end else begin
            file_load_strobe <= tick == stc_pkg::T_T40 && store_rdata_dec
                             && rdata_avail_q;
        end
    end

    // alu load falls at t20 of the cycle after the one that started it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alu_pend_q      <= 1'b0;
            alu_load_strobe <= 1'b0;
        end else begin
            if (tick == stc_pkg::T_LAST) begin
                alu_pend_q <= rdata_alu_dec && !alu_hold_q;
            end
            alu_load_strobe <= tick == stc_pkg::T_T20 && alu_pend_q
                            && rdata_avail_q;
        end
    end

    // ********************************************************************
    // error detection
    // ********************************************************************
    // parity is checked only while the ctrl pchk bit is set; with ecc fitted its own verdict counts
    logic perr_evt;
    logic perr_clr;
    assign perr_evt = pos == stc_pkg::P_E500 && storage_read_data_gate
                   && !main_store_write_flag && ctrl_q[stc_pkg::CTRL_PCHK_BIT]
                   && (ctrl_q[stc_pkg::CTRL_ECC_BIT] ? ecc_uncorrectable
                                                     : |byte_err);

    // a new error beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            perr_q <= 1'b0;
        end else if (perr_evt) begin
            perr_q <= 1'b1;
        end else if (perr_clr) begin
            perr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            parity_error <= 1'b0;
        end else begin
            parity_error <= perr_q || perr_evt;
        end
    end

    // ********************************************************************
    // apb slave
    // ********************************************************************
    // one wait state: data is registered on the same edge that raises pready
    logic acc;
    logic hit;
    assign acc = psel && penable && pready;
    assign hit = paddr == stc_pkg::OFS_CTRL || paddr == stc_pkg::OFS_STATUS
              || paddr == stc_pkg::OFS_POS;
    assign perr_clr = acc && pwrite && paddr == stc_pkg::OFS_STATUS
                   && pwdata[stc_pkg::ST_PERR_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= '0;
            if (!pwrite) begin
                unique case (paddr)
                    stc_pkg::OFS_CTRL:   prdata[1:0] <= ctrl_q;
                    stc_pkg::OFS_STATUS: prdata[5:0] <= {prot_q,
                        main_store_write_flag, alu_hold_q, store_hold_q,
                        resync_hold, perr_q};
                    stc_pkg::OFS_POS:    prdata[6:0] <= pos;
                    default:             prdata      <= '0;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= stc_pkg::CTRL_RST;
        end else if (acc && pwrite && paddr == stc_pkg::OFS_CTRL) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    write_flag_time_a: assert property (
        $rose(main_store_write_flag) |-> $past(pos) == stc_pkg::P_E160
    ) else $error("write flag rose off E160");

    strobe_needs_flag_a: assert property (
        (upper_byte_store_strobe || lower_byte_store_strobe)
        |-> $past(main_store_write_flag)
    ) else $error("store strobe without write flag");

    hold_set_time_a: assert property (
        $fell(store_side_read_hold_n) |-> $past(pos, 2) == stc_pkg::P_E040
    ) else $error("store hold fell off E040");

    write_hold_clr_a: assert property (
        (pos == stc_pkg::P_E160 && write_q) |-> ##2
        (store_side_read_hold_n && alu_side_read_hold_n)
    ) else $error("write did not release holds");

    read_hold_span_a: assert property (
        (pos == stc_pkg::P_E160 && store_hold_q && !write_q)
        |-> ##2 (!store_side_read_hold_n) [*8]
    ) else $error("read store hold released early");

    block_on_hold_a: assert property (
        (store_hold_q && store_rdata_dec) |=> block_next_load
    ) else $error("dependent load not blocked");

    read_gate_time_a: assert property (
        $rose(storage_read_data_gate) |-> $past(pos) == stc_pkg::P_E400
        && !main_store_write_flag
    ) else $error("read gate bad timing");

    select_window_a: assert property (
        !protect_unit_register_select_n |-> prot_q && !bit4_q
        && pos > stc_pkg::P_E040 && pos <= stc_pkg::P_E150
    ) else $error("protect select outside window");

    ecc_no_access_a: assert property (
        !ecc_register_select_n |-> !storage_access_initiate
    ) else $error("ecc select started storage");

    file_load_time_a: assert property (
        file_load_strobe |-> $past(tick) == stc_pkg::T_T40
        && $past(pos) > stc_pkg::P_E500
    ) else $error("file load strobe too early");

endmodule
`default_nettype wire

/* File: test_storage_interface_timing_control.sv */
// self-checking bench for the storage interface timing control block
`timescale 1ns/1ps
`default_nettype none
module test_storage_interface_timing_control;
    logic        clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, pready, pslverr, corrupt = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        load_addr_dec = 1'h0, load_wdata_dec = 1'h0;
    logic        store_rdata_dec = 1'h0, rdata_alu_dec = 1'h0;
    logic [4:0]  addr_src_reg = 5'h00;
    logic        maint_block_access = 1'h0, ecc_uncorrectable = 1'h0;
    logic        register_address_bit4 = 1'h0, word_access = 1'h0;
    logic        byte_addr_bit15 = 1'h0;
    logic [15:0] read_data;
    logic [1:0]  read_parity;
    logic        main_store_write_flag, upper_byte_store_strobe;
    logic        lower_byte_store_strobe, store_side_read_hold_n;
    logic        alu_side_read_hold_n, storage_read_data_gate;
    logic        protect_unit_register_select_n, ecc_register_select_n;
    logic        protect_unit_read_gate, storage_access_initiate;
    logic        resync_hold, block_next_load, file_load_strobe;
    logic        alu_load_strobe, parity_error;
    logic [6:0]  p = 7'h00;
    logic [31:0] seed = 32'h00014CDE;
    logic [32:0] q[$];
    int          miscompares = 0, num_checks = 0;
    storage_interface_timing_control dut (
        .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .load_addr_dec, .load_wdata_dec, .store_rdata_dec,
        .rdata_alu_dec, .addr_src_reg, .maint_block_access,
        .register_address_bit4, .word_access, .byte_addr_bit15, .read_data,
        .read_parity, .ecc_uncorrectable, .main_store_write_flag,
        .upper_byte_store_strobe, .lower_byte_store_strobe,
        .store_side_read_hold_n, .alu_side_read_hold_n,
        .storage_read_data_gate, .protect_unit_register_select_n,
        .ecc_register_select_n, .protect_unit_read_gate,
        .storage_access_initiate, .resync_hold, .block_next_load,
        .file_load_strobe, .alu_load_strobe, .parity_error
    );
    main_store_model ms (
        .clk, .start(storage_access_initiate), .corrupt, .read_data,
        .read_parity
    );
    // ********************************************************************
    // clock, position and helpers
    // ********************************************************************
    initial begin
        forever #5 clk = ~clk;
    end
    // own slice position, reset like the block's so expectations are ours
    always @(posedge clk) begin
        p <= (sys_rst || p == 7'h4F) ? 7'h00 : p + 7'h01;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic at(input int n);
        do @(negedge clk); while (p != n);
    endtask
    // one transfer, held until pready; reads queue their expected answer
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        if (!w) q.push_back(e);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // each read answer meets the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'h1 && !pwrite) begin
            cmp({pslverr, prdata}, q.pop_front());
        end
    end
    // one slice: 0 read, 1 write, 2 protect, 3 ecc reg, 4 late address
    task automatic slice(input int k);
        r = xs();
        at(79);
        @(posedge clk);
        load_addr_dec <= (k != 4);
        addr_src_reg <= (k < 2 || k == 4) ? 5'(r % 30) : {4'hF, k == 3};
        register_address_bit4 <= (k == 3);
        word_access <= r[5];
        byte_addr_bit15 <= r[6];
        at(8);
        cmp(storage_access_initiate, k < 2);
        cmp(protect_unit_register_select_n, k != 2);
        cmp(ecc_register_select_n, k != 3);
        cmp(protect_unit_read_gate, k == 2);
        if (k < 2) cmp(store_side_read_hold_n | alu_side_read_hold_n,
                       1'h0);
        at(9);
        @(posedge clk);
        load_addr_dec <= 1'h0;
        load_wdata_dec <= (k == 1);
        at(16);
        cmp(main_store_write_flag, 0);
        at(17);
        cmp(main_store_write_flag, k == 1);
        at(19);
        cmp(upper_byte_store_strobe,
            k == 1 && !(byte_addr_bit15 && !word_access));
        cmp(lower_byte_store_strobe,
            k == 1 && (byte_addr_bit15 || word_access));
        if (k < 2) cmp(store_side_read_hold_n & alu_side_read_hold_n,
                       k == 1);
        @(posedge clk);
        load_wdata_dec <= 1'h0;
        store_rdata_dec <= (k == 0);
        rdata_alu_dec <= (k == 0);
        load_addr_dec <= (k == 4);
        at(20);
        @(posedge clk);
        load_addr_dec <= 1'h0;
        at(25);
        cmp({resync_hold, storage_access_initiate}, {k == 4, 1'h0});
        if (k != 1) cmp(block_next_load, k == 4 || k == 0);
        at(40);
        cmp(storage_read_data_gate, 0);
        if (k == 0) cmp(alu_side_read_hold_n, 0);
        at(42);
        if (k == 0) cmp(alu_side_read_hold_n, 1);
        cmp(storage_read_data_gate, k == 0 || k == 3);
        at(52);
        if (k == 0) cmp(store_side_read_hold_n, 0);
        // alu transfer lands one cycle after E520, file load after E540
        at(53);
        cmp({alu_load_strobe, file_load_strobe}, {k == 0, 1'h0});
        at(55);
        cmp({file_load_strobe, alu_load_strobe}, {k == 0, 1'h0});
        if (k == 0) cmp({store_side_read_hold_n, parity_error},
                        {1'h1, corrupt});
        at(58);
        if (k == 0) cmp(block_next_load, 0);
        @(posedge clk);
        store_rdata_dec <= 1'h0;
        rdata_alu_dec <= 1'h0;
    endtask
    // ********************************************************************
    // main sequence and watchdog
    // ********************************************************************
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        r = xs();
        apb(1'h0, 12'h000, 32'h0, 33'h2);
        apb(1'h1, 12'h000, r, 33'h0);
        apb(1'h0, 12'h000, 32'h0, {31'h0, r[1:0]});
        apb(1'h1, 12'h000, 32'h2, 33'h0);
        apb(1'h1, 12'h00C, r, 33'h0);
        apb(1'h0, 12'h00C, 32'h0, {1'h1, 32'h0});
        for (int k = 0; k < 5; k++) slice(k);
        @(posedge clk);
        corrupt <= 1'h1;
        slice(0);
        corrupt <= 1'h0;
        apb(1'h0, 12'h004, 32'h0, 33'h1);
        apb(1'h1, 12'h004, 32'h1, 33'h0);
        repeat (2) @(negedge clk);
        cmp(parity_error, 0);
        cmp(q.size(), 0);
        stop_test();
    end
    // a hang costs a mismatch and ends the run
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
